// ==== shared/slcc_pkg.sv ====
// package of constants and types for the system link channel control
package slcc_pkg;

  // ************************************************
  // storage and character layout
  // ************************************************
  localparam int STORE_AW = 8;
  localparam int CHAR_W = 8;
  localparam int CHAR_MARK_BIT = 7;
  localparam logic [6:0] GROUP_MARK_CODE = 7'h3f;

  // ************************************************
  // apb register offsets
  // ************************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_INDIC = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_MEM_PTR = 8'h18;
  localparam logic [7:0] OFS_MEM_DATA = 8'h1c;

  // ************************************************
  // control register fields
  // ************************************************
  localparam int CTRL_READ = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_SEND_REQ = 2;
  localparam int CTRL_EOT_RESET = 3;
  localparam int CTRL_RESTART = 4;
  localparam int CTRL_LOAD_MODE = 5;

  // ************************************************
  // indicator register fields (bit = code - 1)
  // ************************************************
  localparam int IND_PEER_ERROR = 0;
  localparam int IND_PEER_ENDED = 1;
  localparam int IND_PEER_WANT_SEND = 3;
  localparam int IND_PEER_WRITE = 5;
  localparam int IND_PEER_READ = 6;
  localparam int IND_PEER_STOPPED = 7;

  // ************************************************
  // status register fields
  // ************************************************
  localparam int ST_BUSY = 0;
  localparam int ST_HALTED = 1;
  localparam int ST_ERROR = 2;
  localparam int ST_ENDED = 3;
  localparam int ST_EOT_PENDING = 4;
  localparam int ST_WANT_SEND = 5;

  // ************************************************
  // interrupt fields and reset values
  // ************************************************
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WANT_SEND = 1;
  localparam int IRQ_PEER_READ = 2;
  localparam int IRQ_PEER_WRITE = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [STORE_AW-1:0] ADDR_RST = 8'h00;

  typedef enum {XF_IDLE, XF_READ_WAIT, XF_WRITE_WAIT, XF_RX, XF_TX} slcc_xfer_t;

endpackage

// ==== hdl/slcc_store.sv ====
// character storage with two read ports and one write port
`timescale 1ns/1ns
module slcc_store (
  input wire logic clk,
  input wire logic we,
  input wire logic [slcc_pkg::STORE_AW-1:0] waddr,
  input wire logic [slcc_pkg::CHAR_W-1:0] wdata,
  input wire logic [slcc_pkg::STORE_AW-1:0] raddr_a,
  output logic [slcc_pkg::CHAR_W-1:0] rdata_a,
  input wire logic [slcc_pkg::STORE_AW-1:0] raddr_b,
  output logic [slcc_pkg::CHAR_W-1:0] rdata_b
);
  import slcc_pkg::*;

  logic [CHAR_W-1:0] mem [0:(1<<STORE_AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule // slcc_store

// ==== hdl/slcc_top.sv ====
// channel control between two peer machines, apb slave and link
`timescale 1ns/1ns

// Operation
// - transfer runs until a group-mark with word-mark is met; then end signal sent
// - while attempting a read, a level tells the peer (its code 7)
// - while attempting a write, a level tells the peer (its code 6)
// - code 8 indicator shows whether the peer is running or stopped
// - code 4 indicator shows the peer announced it wants to send
// - send-request command signals the peer that this machine wants to send
// - on a transfer error, run the transfer to its end then halt
// - code 1 indicator reports a transfer error in the peer
// - code 2 indicator reports that the peer terminated the transfer
// - eot-reset command clears the peer's end-of-transmission circuitry
// - a read attempt moves nothing until the peer executes a matching write
// - a write does not start while the receiving peer is halted
// - storage address register holds the position reached after a transfer
// - receiver ending without sender's end shows input area was exhausted
// - move mode sends seven bits without mark; load mode includes the mark
module slcc_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slcc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic lnk_running,
  output logic lnk_want_send,
  output logic lnk_read_attempt,
  output logic lnk_write_attempt,
  output logic lnk_error,
  output logic lnk_ended,
  output logic lnk_end_pulse,
  output logic lnk_eot_reset,
  output logic [slcc_pkg::CHAR_W-1:0] lnk_char,
  output logic lnk_char_valid,
  output logic lnk_char_parity,
  input wire logic peer_running,
  input wire logic peer_want_send,
  input wire logic peer_read_attempt,
  input wire logic peer_write_attempt,
  input wire logic peer_error,
  input wire logic peer_ended,
  input wire logic peer_end_pulse,
  input wire logic peer_eot_reset,
  input wire logic [slcc_pkg::CHAR_W-1:0] peer_char,
  input wire logic peer_char_valid,
  input wire logic peer_char_parity
);
  import slcc_pkg::*;

  // ************************************************
  // state
  // ************************************************
  slcc_xfer_t state_reg, state_next;
  logic [STORE_AW-1:0] addr_reg, addr_next;
  logic [STORE_AW-1:0] mem_ptr_reg, mem_ptr_next;
  logic load_mode_reg, load_mode_next;
  logic halted_reg, halted_next;
  logic error_reg, error_next;
  logic ended_reg, ended_next;
  logic pending_reg, pending_next;
  logic want_send_reg, want_send_next;
  logic end_pulse_reg, end_pulse_next;
  logic eot_reset_reg, eot_reset_next;
  logic [CHAR_W-1:0] char_reg, char_next;
  logic char_valid_reg, char_valid_next;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic irq_reg, irq_next;
  logic [2:0] peer_prev_reg, peer_prev_next;
  logic [31:0] prdata_reg, prdata_next;

  logic [CHAR_W-1:0] store_rd_a;
  logic [CHAR_W-1:0] store_rd_b;
  logic store_we;
  logic [STORE_AW-1:0] store_waddr;
  logic [CHAR_W-1:0] store_wdata;

  logic apb_setup;
  logic apb_acc;
  logic apb_wr;
  logic mapped;
  logic [5:0] cmd;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] w1c;
  logic at_group_mark;
  logic can_start;
  logic finish;
  logic [7:0] indic;
  logic [7:0] stat;

  slcc_store u_store (
    .clk(clk),
    .we(store_we),
    .waddr(store_waddr),
    .wdata(store_wdata),
    .raddr_a(addr_reg),
    .rdata_a(store_rd_a),
    .raddr_b(mem_ptr_reg),
    .rdata_b(store_rd_b)
  );

  // ************************************************
  // next-state logic
  // ************************************************
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    mem_ptr_next = mem_ptr_reg;
    load_mode_next = load_mode_reg;
    halted_next = halted_reg;
    error_next = error_reg;
    ended_next = ended_reg;
    pending_next = pending_reg;
    want_send_next = want_send_reg;
    end_pulse_next = 1'b0;
    eot_reset_next = 1'b0;
    char_next = char_reg;
    char_valid_next = 1'b0;
    irq_mask_next = irq_mask_reg;
    prdata_next = prdata_reg;
    store_we = 1'b0;
    store_waddr = addr_reg;
    store_wdata = store_rd_a;
    finish = 1'b0;

    apb_setup = psel & ~penable;
    apb_acc = psel & penable;
    apb_wr = apb_acc & pwrite;
    mapped = (paddr == OFS_CTRL) || (paddr == OFS_ADDR) || (paddr == OFS_INDIC) || (paddr == OFS_STAT) ||
             (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK) || (paddr == OFS_MEM_PTR) ||
             (paddr == OFS_MEM_DATA);
    cmd = (apb_wr && paddr == OFS_CTRL) ? pwdata[5:0] : 6'h00;
    w1c = (apb_wr && paddr == OFS_IRQ_STAT) ? pwdata[IRQ_W-1:0] : 4'h0;

    // indicators are live peer levels, reading leaves them alone
    indic = 8'h00;
    indic[IND_PEER_ERROR] = peer_error;
    indic[IND_PEER_ENDED] = peer_ended;
    indic[IND_PEER_WANT_SEND] = peer_want_send;
    indic[IND_PEER_WRITE] = peer_write_attempt;
    indic[IND_PEER_READ] = peer_read_attempt;
    indic[IND_PEER_STOPPED] = ~peer_running;
    stat = 8'h00;
    stat[ST_BUSY] = (state_reg != XF_IDLE);
    stat[ST_HALTED] = halted_reg;
    stat[ST_ERROR] = error_reg;
    stat[ST_ENDED] = ended_reg;
    stat[ST_EOT_PENDING] = pending_reg;
    stat[ST_WANT_SEND] = want_send_reg;

    at_group_mark = store_rd_a[CHAR_MARK_BIT] && (store_rd_a[6:0] == GROUP_MARK_CODE);
    can_start = ~halted_reg & ~pending_reg;

    // register writes
    if (apb_wr && paddr == OFS_CTRL) begin
      load_mode_next = pwdata[CTRL_LOAD_MODE];
    end
    if (apb_wr && paddr == OFS_ADDR && state_reg == XF_IDLE) begin
      addr_next = pwdata[STORE_AW-1:0];
    end
    if (apb_wr && paddr == OFS_IRQ_MASK) begin
      irq_mask_next = pwdata[IRQ_W-1:0];
    end
    if (apb_wr && paddr == OFS_MEM_PTR) begin
      mem_ptr_next = pwdata[STORE_AW-1:0];
    end
    if (apb_acc && paddr == OFS_MEM_DATA && state_reg != XF_RX) begin
      if (pwrite) begin
        store_we = 1'b1;
        store_waddr = mem_ptr_reg;
        store_wdata = pwdata[CHAR_W-1:0];
      end
      mem_ptr_next = mem_ptr_reg + 8'h01;
    end

    // want-send level stays until the peer starts reading
    if (peer_read_attempt) begin
      want_send_next = 1'b0;
    end
    if (cmd[CTRL_SEND_REQ]) begin
      want_send_next = 1'b1;
    end
    eot_reset_next = cmd[CTRL_EOT_RESET];
    if (cmd[CTRL_RESTART]) begin
      halted_next = 1'b0;
    end
    if (peer_eot_reset) begin
      ended_next = 1'b0;
      error_next = 1'b0;
      pending_next = 1'b0;
    end

    // transfer sequencer
    case (state_reg)
      XF_IDLE: begin
        if (cmd[CTRL_READ] && can_start) begin
          state_next = XF_READ_WAIT;
        end else if (cmd[CTRL_WRITE] && can_start) begin
          state_next = XF_WRITE_WAIT;
        end
      end
      XF_READ_WAIT: begin
        if (peer_write_attempt && peer_running) begin
          state_next = XF_RX;
        end
      end
      XF_WRITE_WAIT: begin
        if (peer_read_attempt && peer_running) begin
          state_next = XF_TX;
        end
      end
      XF_TX: begin
        if (peer_end_pulse) begin
          finish = 1'b1;
        end else if (at_group_mark) begin
          finish = 1'b1;
          end_pulse_next = 1'b1;
          ended_next = 1'b1;
        end else begin
          char_next = load_mode_reg ? store_rd_a : {1'b0, store_rd_a[6:0]};
          char_valid_next = 1'b1;
          addr_next = addr_reg + 8'h01;
        end
      end
      XF_RX: begin
        if (peer_char_valid) begin
          if (at_group_mark) begin
            finish = 1'b1;
            end_pulse_next = 1'b1;
            ended_next = 1'b1;
          end else begin
            store_we = 1'b1;
            store_waddr = addr_reg;
            store_wdata = load_mode_reg ? peer_char : {store_rd_a[CHAR_MARK_BIT], peer_char[6:0]};
            addr_next = addr_reg + 8'h01;
            if (~^{peer_char, peer_char_parity}) begin
              error_next = 1'b1;
            end
          end
        end
        if (peer_end_pulse) begin
          finish = 1'b1;
        end
      end
      default: begin
        state_next = XF_IDLE;
      end
    endcase
    if (finish) begin
      state_next = XF_IDLE;
      pending_next = 1'b1;
      halted_next = halted_next | error_next;
    end

    // sticky events, a new event wins over a clear
    peer_prev_next = {peer_write_attempt, peer_read_attempt, peer_want_send};
    events = 4'h0;
    events[IRQ_DONE] = finish;
    events[IRQ_WANT_SEND] = peer_want_send & ~peer_prev_reg[0];
    events[IRQ_PEER_READ] = peer_read_attempt & ~peer_prev_reg[1];
    events[IRQ_PEER_WRITE] = peer_write_attempt & ~peer_prev_reg[2];
    irq_stat_next = (irq_stat_reg & ~w1c) | events;
    irq_next = |(irq_stat_next & irq_mask_next);

    // read data is captured in the setup phase
    if (apb_setup) begin
      case (paddr)
        OFS_CTRL: prdata_next = {26'h0, load_mode_reg, 5'h00};
        OFS_ADDR: prdata_next = {24'h0, addr_reg};
        OFS_INDIC: prdata_next = {24'h0, indic};
        OFS_STAT: prdata_next = {24'h0, stat};
        OFS_IRQ_STAT: prdata_next = {28'h0, irq_stat_reg};
        OFS_IRQ_MASK: prdata_next = {28'h0, irq_mask_reg};
        OFS_MEM_PTR: prdata_next = {24'h0, mem_ptr_reg};
        OFS_MEM_DATA: prdata_next = {24'h0, store_rd_b};
        default: prdata_next = 32'h0;
      endcase
    end
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= XF_IDLE;
      addr_reg <= ADDR_RST;
      mem_ptr_reg <= ADDR_RST;
      load_mode_reg <= 1'b0;
      halted_reg <= 1'b0;
      error_reg <= 1'b0;
      ended_reg <= 1'b0;
      pending_reg <= 1'b0;
      want_send_reg <= 1'b0;
      end_pulse_reg <= 1'b0;
      eot_reset_reg <= 1'b0;
      char_reg <= 8'h00;
      char_valid_reg <= 1'b0;
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= IRQ_MASK_RST;
      irq_reg <= 1'b0;
      peer_prev_reg <= 3'h0;
      prdata_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      mem_ptr_reg <= mem_ptr_next;
      load_mode_reg <= load_mode_next;
      halted_reg <= halted_next;
      error_reg <= error_next;
      ended_reg <= ended_next;
      pending_reg <= pending_next;
      want_send_reg <= want_send_next;
      end_pulse_reg <= end_pulse_next;
      eot_reset_reg <= eot_reset_next;
      char_reg <= char_next;
      char_valid_reg <= char_valid_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
      peer_prev_reg <= peer_prev_next;
      prdata_reg <= prdata_next;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign prdata = prdata_reg;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign irq = irq_reg;
  assign lnk_running = ~halted_reg;
  assign lnk_want_send = want_send_reg;
  assign lnk_read_attempt = (state_reg == XF_READ_WAIT) || (state_reg == XF_RX);
  assign lnk_write_attempt = (state_reg == XF_WRITE_WAIT) || (state_reg == XF_TX);
  assign lnk_error = error_reg;
  assign lnk_ended = ended_reg;
  assign lnk_end_pulse = end_pulse_reg;
  assign lnk_eot_reset = eot_reset_reg;
  assign lnk_char = char_reg;
  assign lnk_char_valid = char_valid_reg;
  assign lnk_char_parity = ~^char_reg;

endmodule // slcc_top

// ==== tb/slcc_props.sv ====
// link channel control assertions
`timescale 1ns/1ns
module slcc_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slcc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic lnk_running,
  input wire logic lnk_want_send,
  input wire logic lnk_read_attempt,
  input wire logic lnk_write_attempt,
  input wire logic lnk_ended,
  input wire logic lnk_end_pulse,
  input wire logic lnk_eot_reset,
  input wire logic lnk_char_valid,
  input wire logic peer_running,
  input wire logic peer_eot_reset
);
  import slcc_pkg::*;
  logic ctl_wr;
  assign ctl_wr = psel && penable && pwrite && paddr == OFS_CTRL;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ****
  // link checks
  // ****
  want_send_a: assert property (ctl_wr && pwdata[CTRL_SEND_REQ] |=> lnk_want_send)
    else $error("send request not raised");
  eot_pulse_a: assert property (ctl_wr && pwdata[CTRL_EOT_RESET] |=> lnk_eot_reset ##1 !lnk_eot_reset)
    else $error("eot reset pulse wrong");
  tx_in_write_a: assert property (lnk_char_valid |-> $past(lnk_write_attempt))
    else $error("char sent outside write");
  no_tx_stopped_a: assert property ((lnk_write_attempt && !lnk_char_valid && !peer_running) [*2] |=> !lnk_char_valid)
    else $error("char sent to stopped peer");
  end_pulse_a: assert property (lnk_end_pulse |=> lnk_ended && !lnk_end_pulse)
    else $error("end pulse wrong");
  halt_at_end_a: assert property ($fell(lnk_running) |-> !lnk_read_attempt && !lnk_write_attempt)
    else $error("halt inside transfer");
  eot_clear_a: assert property (peer_eot_reset |=> !lnk_ended)
    else $error("ended not cleared");
  ended_hold_a: assert property (lnk_ended && !peer_eot_reset |=> lnk_ended)
    else $error("ended dropped");
endmodule // slcc_props

bind slcc_top slcc_props u_props (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .lnk_running,
  .lnk_want_send, .lnk_read_attempt, .lnk_write_attempt, .lnk_ended, .lnk_end_pulse, .lnk_eot_reset,
  .lnk_char_valid, .peer_running, .peer_eot_reset);

// ==== tb/slcc_peer_model.sv ====
// model of the peer machine at the far end of the link
`timescale 1ns/1ns
module slcc_peer_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic peer_running,
  input wire logic bad,
  input wire logic [2:0] req,
  input wire logic [7:0] msg_len,
  input wire logic lnk_read_attempt,
  input wire logic lnk_end_pulse,
  input wire logic lnk_eot_reset,
  input wire logic [slcc_pkg::CHAR_W-1:0] lnk_char,
  input wire logic lnk_char_valid,
  input wire logic lnk_char_parity,
  output logic peer_read_attempt,
  output logic peer_write_attempt,
  output logic peer_ended,
  output logic peer_end_pulse,
  output logic peer_eot_reset,
  output logic [slcc_pkg::CHAR_W-1:0] peer_char,
  output logic peer_char_valid,
  output logic peer_char_parity
);
  import slcc_pkg::*;
  logic [7:0] rx_q[$];
  logic [7:0] left;
  logic [7:0] seq;
  logic par_bad;
  always @(posedge clk) begin
    peer_char <= ~peer_char;
    peer_char_valid <= 1'b0;
    peer_end_pulse <= 1'b0;
    peer_eot_reset <= req[2];
    if (reset) begin
      {peer_read_attempt, peer_write_attempt, peer_ended} <= 3'h0;
      peer_char <= 8'h00;
      peer_char_parity <= 1'b1;
      seq <= 8'h41;
      left <= 8'h00;
      par_bad <= 1'b0;
    end else begin
      if (req[0]) peer_read_attempt <= 1'b1;
      if (req[1]) begin
        peer_write_attempt <= 1'b1;
        left <= msg_len;
      end
      if (lnk_eot_reset) peer_ended <= 1'b0;
      if (peer_read_attempt && lnk_char_valid) rx_q.push_back(lnk_char);
      if (peer_read_attempt && lnk_char_valid && !(^{lnk_char, lnk_char_parity})) par_bad <= 1'b1;
      if (peer_read_attempt && lnk_end_pulse) peer_read_attempt <= 1'b0;
      if (peer_write_attempt && lnk_read_attempt && peer_running) begin
        if (lnk_end_pulse || left == 8'h00) begin
          peer_write_attempt <= 1'b0;
          peer_end_pulse <= !lnk_end_pulse;
          peer_ended <= !lnk_end_pulse;
        end else begin
          peer_char <= seq;
          peer_char_parity <= (~^seq) ^ bad;
          peer_char_valid <= 1'b1;
          seq <= seq + 8'h01;
          left <= left - 8'h01;
        end
      end
    end
  end
endmodule // slcc_peer_model

// ==== tb/system_link_channel_control_bench.sv ====
// self-checking bench for the link channel control
`timescale 1ns/1ns
module system_link_channel_control_bench;
  import slcc_pkg::*;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic [7:0] paddr, msg_len, lnk_char, peer_char;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] req;
  logic lnk_running, lnk_want_send, lnk_read_attempt, lnk_write_attempt, lnk_error, lnk_ended, lnk_end_pulse;
  logic lnk_eot_reset, lnk_char_valid, lnk_char_parity, peer_running, peer_want_send, peer_read_attempt;
  logic peer_write_attempt, peer_error, peer_ended, peer_end_pulse, peer_eot_reset, peer_char_valid, peer_char_parity;
  int checks, bad_count;
  slcc_top DUT (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .lnk_running, .lnk_want_send, .lnk_read_attempt, .lnk_write_attempt, .lnk_error, .lnk_ended, .lnk_end_pulse,
    .lnk_eot_reset, .lnk_char, .lnk_char_valid, .lnk_char_parity, .peer_running, .peer_want_send,
    .peer_read_attempt, .peer_write_attempt, .peer_error, .peer_ended, .peer_end_pulse, .peer_eot_reset,
    .peer_char, .peer_char_valid, .peer_char_parity);
  slcc_peer_model PEER (.clk, .reset, .peer_running, .bad(peer_error), .req, .msg_len, .lnk_read_attempt,
    .lnk_end_pulse, .lnk_eot_reset, .lnk_char, .lnk_char_valid, .lnk_char_parity, .peer_read_attempt,
    .peer_write_attempt,
    .peer_ended, .peer_end_pulse, .peer_eot_reset, .peer_char, .peer_char_valid, .peer_char_parity);
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    repeat (3) @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic pulse(input logic [2:0] m);
    req <= m;
    @(posedge clk);
    req <= 3'h0;
  endtask
  task automatic idle();
    while ((lnk_read_attempt | lnk_write_attempt) !== 1'b0) begin
      @(posedge clk);
    end
  endtask
  task results();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****
  // clock, watchdog and tests
  // ****
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, req, msg_len} <= {4'h8, 8'h00, 32'h0, 3'h0, 8'h03};
    {peer_running, peer_want_send, peer_error} <= 3'b100;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rdchk(8'h40, 32'h0);
    chk(serr, 1'b1);
    peer_running <= 1'b0;
    rdchk(OFS_INDIC, 32'h80);
    rdchk(OFS_INDIC, 32'h80);
    {peer_running, peer_want_send} <= 2'b11;
    rdchk(OFS_INDIC, 32'h08);
    peer_want_send <= 1'b0;
    xfer(1'b1, OFS_CTRL, 32'h04);
    @(negedge clk);
    chk(lnk_want_send, 1'b1);
    xfer(1'b1, OFS_IRQ_MASK, 32'hf);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1);
    xfer(1'b1, OFS_IRQ_STAT, 32'hf);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    xfer(1'b1, OFS_MEM_PTR, 32'h10);
    for (int i = 0; i < 4; i++) xfer(1'b1, OFS_MEM_DATA, 32'h0);
    xfer(1'b1, OFS_ADDR, 32'h10);
    xfer(1'b1, OFS_CTRL, 32'h01);
    rdchk(OFS_ADDR, 32'h10);
    chk(lnk_read_attempt, 1'b1);
    pulse(3'h2);
    idle();
    rdchk(OFS_ADDR, 32'h13);
    rdchk(OFS_INDIC, 32'h02);
    xfer(1'b1, OFS_MEM_PTR, 32'h10);
    for (int i = 0; i < 3; i++) rdchk(OFS_MEM_DATA, 32'h41 + i);
    pulse(3'h4);
    xfer(1'b1, OFS_CTRL, 32'h08);
    rdchk(OFS_INDIC, 32'h0);
    xfer(1'b1, OFS_MEM_PTR, 32'h20);
    xfer(1'b1, OFS_MEM_DATA, 32'hc1);
    xfer(1'b1, OFS_MEM_DATA, 32'h42);
    xfer(1'b1, OFS_MEM_DATA, 32'hbf);
    chk(lnk_write_attempt, 1'b0);
    xfer(1'b1, OFS_ADDR, 32'h20);
    xfer(1'b1, OFS_CTRL, 32'h02);
    repeat (2) @(posedge clk);
    chk(lnk_write_attempt, 1'b1);
    pulse(3'h1);
    idle();
    chk(32'(PEER.rx_q.size()), 32'h2);
    chk(PEER.rx_q[0], 8'h41);
    chk(PEER.rx_q[1], 8'h42);
    rdchk(OFS_ADDR, 32'h22);
    chk(lnk_ended, 1'b1);
    pulse(3'h4);
    xfer(1'b1, OFS_CTRL, 32'h08);
    peer_error <= 1'b1;
    xfer(1'b1, OFS_ADDR, 32'h10);
    xfer(1'b1, OFS_CTRL, 32'h01);
    pulse(3'h2);
    idle();
    rdchk(OFS_STAT, 32'h16);
    rdchk(OFS_INDIC, 32'h03);
    chk(lnk_running, 1'b0);
    chk(lnk_error, 1'b1);
    peer_error <= 1'b0;
    pulse(3'h4);
    xfer(1'b1, OFS_CTRL, 32'h18);
    peer_running <= 1'b0;
    pulse(3'h1);
    xfer(1'b1, OFS_ADDR, 32'h20);
    xfer(1'b1, OFS_CTRL, 32'h22);
    repeat (8) @(posedge clk);
    chk(32'(PEER.rx_q.size()), 32'h2);
    peer_running <= 1'b1;
    idle();
    chk(32'(PEER.rx_q.size()), 32'h4);
    chk(PEER.rx_q[2], 8'hc1);
    chk(PEER.rx_q[3], 8'h42);
    chk(PEER.par_bad, 1'b0);
    results();
  end
endmodule // system_link_channel_control_bench
